// ===== vliw_dispatch_defs.svh
// constants for the packet dispatcher and its register files
`ifndef VLIW_DISPATCH_DEFS_SVH
`define VLIW_DISPATCH_DEFS_SVH
`define FP_SLOTS 8
`define FP_BYTES 32'h0000_0020
`define FP_RESET_ADDR 32'h0000_0000
`define RF_REGS 16
`define NOP_BITS 31'h0000_0000
`define ADDR_UNIT_A 3
`define ADDR_UNIT_B 4
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2
`endif

// ===== vliw_dispatch_pkg.sv
// types for the packet dispatcher
package vliw_dispatch_pkg;
   typedef enum logic [1:0] {
      ST_FETCH = 2'b01,
      ST_DISPATCH = 2'b10
   } disp_state_t;
   // unit order on the issue vector; side a is slots 0-3
   typedef enum logic [2:0] {
      LOGIC_UNIT_A = 3'h0,
      SHIFT_BRANCH_UNIT_A = 3'h1,
      MULTIPLY_UNIT_A = 3'h2,
      ADDRESS_UNIT_A = 3'h3,
      ADDRESS_UNIT_B = 3'h4,
      MULTIPLY_UNIT_B = 3'h5,
      SHIFT_BRANCH_UNIT_B = 3'h6,
      LOGIC_UNIT_B = 3'h7
   } unit_t;
endpackage

// ===== vliw_packet_dispatch.sv
// fetch, execute-packet dispatch, register files and address units
`timescale 1ns/1ps
`include "vliw_dispatch_defs.svh"

module vliw_packet_dispatch (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // program memory
   output logic fetch_req_ff,
   output logic [31:0] fetch_addr_ff,
   input wire logic fetch_valid,
   input wire logic [255:0] fetch_data,
   // issue to functional units
   output logic [7:0] issue_mask_ff,
   output logic [7:0] issue_exec_ff,
   output logic [255:0] issue_data_ff,
   // unit register access, index bit 4 selects side b
   input wire logic [7:0][4:0] rd_reg,
   output logic [7:0][31:0] rd_data_ff,
   input wire logic [7:0] result_we,
   input wire logic [7:0][4:0] result_reg,
   input wire logic [7:0][31:0] result_data,
   output logic cross_err_ff,
   // address units a and b
   input wire logic [1:0][4:0] agu_base_reg,
   input wire logic [1:0][14:0] agu_offset,
   input wire logic [1:0] agu_long,
   input wire logic [1:0] agu_circ,
   input wire logic [1:0][4:0] agu_blk_log2,
   input wire logic [1:0][1:0] agu_size,
   output logic [1:0][31:0] agu_addr_ff,
   output logic [1:0][3:0] agu_be_ff
);

   // ----------------------------------------
   // fetch and dispatch sequencing
   // ----------------------------------------
   vliw_dispatch_pkg::disp_state_t state_ff, nxt_state;
   // declared here because the condition test below reads side a
   logic [1:0][15:0][31:0] rf_ff, nxt_rf;
   logic [7:0][31:0] pkt_ff, nxt_pkt;
   logic [2:0] pos_ff, nxt_pos;
   logic [3:0] pk_cnt_ff, nxt_pk_cnt;
   logic nxt_req;
   logic [31:0] nxt_addr;
   logic [7:0] nxt_mask, nxt_exec, chain_mask, cond_pass, nop_slot;
   logic [255:0] nxt_idata;
   logic [2:0] end_slot;
   logic last_pkt;
   logic found;

   // find where the current execute packet ends
   always_comb begin
      end_slot = 3'h7;
      found = 1'b0;
      chain_mask = 8'h00;
      for (int i = 0; i < `FP_SLOTS; i++) begin
         if (!found && 3'(i) >= pos_ff && !pkt_ff[i][0]) begin
            end_slot = 3'(i);
            found = 1'b1;
         end
      end
      // a chain still open at slot 7 is cut there, never carried over
      for (int i = 0; i < `FP_SLOTS; i++) begin
         chain_mask[i] = (3'(i) >= pos_ff) && (3'(i) <= end_slot);
      end
      last_pkt = (end_slot == 3'h7);
   end

   // condition and padding test for each slot
   always_comb begin
      for (int i = 0; i < `FP_SLOTS; i++) begin
         nop_slot[i] = (pkt_ff[i][31:1] == `NOP_BITS);
         cond_pass[i] = (pkt_ff[i][31:29] == 3'h0) ||
            ((rf_ff[0][{1'b0, pkt_ff[i][31:29]}] != 32'h0) ^
             pkt_ff[i][28]);
      end
   end

   always_comb begin
      nxt_state = state_ff;
      nxt_pkt = pkt_ff;
      nxt_pos = pos_ff;
      nxt_pk_cnt = pk_cnt_ff;
      nxt_addr = fetch_addr_ff;
      nxt_mask = 8'h00;
      nxt_exec = 8'h00;
      nxt_idata = issue_data_ff;
      unique case (state_ff)
         vliw_dispatch_pkg::ST_FETCH: begin
            if (fetch_req_ff && fetch_valid) begin
               nxt_pkt = fetch_data;
               nxt_pos = 3'h0;
               nxt_pk_cnt = 4'h0;
               nxt_state = vliw_dispatch_pkg::ST_DISPATCH;
            end
         end
         vliw_dispatch_pkg::ST_DISPATCH: begin
            // one packet a cycle; idle units get a clear mask bit
            nxt_mask = chain_mask;
            nxt_exec = chain_mask & cond_pass & ~nop_slot;
            nxt_idata = pkt_ff;
            nxt_pk_cnt = pk_cnt_ff + 4'h1;
            nxt_pos = end_slot + 3'h1;
            if (last_pkt) begin
               nxt_state = vliw_dispatch_pkg::ST_FETCH;
               nxt_addr = fetch_addr_ff + `FP_BYTES;
            end
         end
      endcase
      nxt_req = (nxt_state == vliw_dispatch_pkg::ST_FETCH);
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_ff <= vliw_dispatch_pkg::ST_FETCH;
         pkt_ff <= '0;
         pos_ff <= 3'h0;
         pk_cnt_ff <= 4'h0;
         fetch_req_ff <= 1'b0;
         fetch_addr_ff <= `FP_RESET_ADDR;
         issue_mask_ff <= 8'h00;
         issue_exec_ff <= 8'h00;
         issue_data_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         pkt_ff <= nxt_pkt;
         pos_ff <= nxt_pos;
         pk_cnt_ff <= nxt_pk_cnt;
         fetch_req_ff <= nxt_req;
         fetch_addr_ff <= nxt_addr;
         issue_mask_ff <= nxt_mask;
         issue_exec_ff <= nxt_exec;
         issue_data_ff <= nxt_idata;
      end
   end

   // ----------------------------------------
   // register files, side a and side b
   // ----------------------------------------
   logic [7:0][31:0] nxt_rd;
   logic nxt_cross_err;
   logic [1:0] xrd_used, xwr_used;
   logic uside, tside, addr_unit;

   // every same-side port is served each cycle; the cross bus carries
   // one read and one write per side, later claims are dropped
   always_comb begin
      nxt_rf = rf_ff;
      nxt_rd = '0;
      nxt_cross_err = 1'b0;
      xrd_used = 2'b00;
      xwr_used = 2'b00;
      uside = 1'b0;
      tside = 1'b0;
      addr_unit = 1'b0;
      for (int u = 0; u < `FP_SLOTS; u++) begin
         uside = (u >= 4);
         addr_unit = (u == `ADDR_UNIT_A) || (u == `ADDR_UNIT_B);
         tside = rd_reg[u][4];
         if (tside == uside) begin
            nxt_rd[u] = rf_ff[tside][rd_reg[u][3:0]];
         end else if (!xrd_used[uside]) begin
            nxt_rd[u] = rf_ff[tside][rd_reg[u][3:0]];
            xrd_used[uside] = 1'b1;
         end else begin
            nxt_cross_err = 1'b1;
         end
         tside = result_reg[u][4];
         // load data from an address unit may land on either side
         if (result_we[u]) begin
            if (tside == uside || addr_unit) begin
               nxt_rf[tside][result_reg[u][3:0]] = result_data[u];
            end else if (!xwr_used[uside]) begin
               nxt_rf[tside][result_reg[u][3:0]] = result_data[u];
               xwr_used[uside] = 1'b1;
            end else begin
               nxt_cross_err = 1'b1;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         rf_ff <= '0;
         rd_data_ff <= '0;
         cross_err_ff <= 1'b0;
      end else begin
         rf_ff <= nxt_rf;
         rd_data_ff <= nxt_rd;
         cross_err_ff <= nxt_cross_err;
      end
   end

   // ----------------------------------------
   // address generation for the two address units
   // ----------------------------------------
   logic [1:0][31:0] nxt_agu_addr, agu_sum, agu_base;
   logic [1:0][3:0] nxt_agu_be;
   logic [31:0] off, wrap;

   // the base may sit on either side, so one side addresses for the other
   always_comb begin
      off = '0;
      wrap = '0;
      agu_base = '0;
      agu_sum = '0;
      nxt_agu_addr = '0;
      nxt_agu_be = '0;
      for (int a = 0; a < 2; a++) begin
         agu_base[a] = rf_ff[agu_base_reg[a][4]][agu_base_reg[a][3:0]];
         off = agu_long[a] ? {17'h0, agu_offset[a]} :
            {27'h0, agu_offset[a][4:0]};
         off = off << agu_size[a];
         agu_sum[a] = agu_base[a] + off;
         wrap = (32'h1 << agu_blk_log2[a]) - 32'h1;
         // circular mode only moves the bits inside the block
         nxt_agu_addr[a] = agu_circ[a] ?
            ((agu_base[a] & ~wrap) | (agu_sum[a] & wrap)) : agu_sum[a];
         unique case (agu_size[a])
            `SIZE_BYTE: nxt_agu_be[a] = 4'h1 << nxt_agu_addr[a][1:0];
            `SIZE_HALF:
               nxt_agu_be[a] = 4'h3 << {nxt_agu_addr[a][1], 1'b0};
            default: nxt_agu_be[a] = 4'hf;
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         agu_addr_ff <= '0;
         agu_be_ff <= '0;
      end else begin
         agu_addr_ff <= nxt_agu_addr;
         agu_be_ff <= nxt_agu_be;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   AST_FETCH_WHOLE: assert property (@(posedge ref_clk) disable iff (!rst_n)
      fetch_req_ff && fetch_valid |=> pkt_ff == $past(fetch_data))
      else $error("fetch packet not captured whole");
   AST_CHAIN_END: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == vliw_dispatch_pkg::ST_DISPATCH && !last_pkt
      |-> pkt_ff[end_slot][0] == 1'b0)
      else $error("execute packet ended on a chained word");
   AST_SPLIT_MAX: assert property (@(posedge ref_clk) disable iff (!rst_n)
      pk_cnt_ff <= 4'h8)
      else $error("more than eight packets from one fetch");
   AST_ONE_PER_CYCLE: assert property (@(posedge ref_clk)
      disable iff (!rst_n)
      state_ff == vliw_dispatch_pkg::ST_DISPATCH
      |=> issue_mask_ff != 8'h00 && $onehot0(issue_mask_ff &
      ~(issue_mask_ff << 1)))
      else $error("dispatch not one contiguous packet");
   AST_HOLD_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == vliw_dispatch_pkg::ST_DISPATCH && !last_pkt
      |=> !fetch_req_ff ##1 (!fetch_req_ff || $past(last_pkt)))
      else $error("fetch requested before packet drained");
   AST_IDLE_UNITS: assert property (@(posedge ref_clk) disable iff (!rst_n)
      (issue_exec_ff & ~issue_mask_ff) == 8'h00)
      else $error("unit executes outside its packet");
   AST_NOP_INERT: assert property (@(posedge ref_clk) disable iff (!rst_n)
      state_ff == vliw_dispatch_pkg::ST_DISPATCH
      |=> (issue_exec_ff & $past(nop_slot)) == 8'h00)
      else $error("padding slot marked for execution");
   AST_AGU_LINEAR: assert property (@(posedge ref_clk) disable iff (!rst_n)
      !agu_circ[0] |=> agu_addr_ff[0] == $past(agu_sum[0]))
      else $error("linear address wrong");
   AST_AGU_WORD: assert property (@(posedge ref_clk) disable iff (!rst_n)
      agu_size[1] == `SIZE_WORD |=> agu_be_ff[1] == 4'hf)
      else $error("word access lanes wrong");

endmodule // vliw_packet_dispatch

// ===== prog_mem_model.sv
// program memory model that answers fetch requests with packets
`timescale 1ns/1ps
module prog_mem_model (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // fetch link
   input wire logic fetch_req,
   input wire logic [31:0] fetch_addr,
   output logic fetch_valid,
   output logic [255:0] fetch_data,
   // idle cycles before each answer
   input wire logic [1:0] lat
);
   logic [1:0] wait_ff;
   // program image; no chain ever crosses a packet edge, tail is nop
   function automatic logic [255:0] image(input logic [31:0] a);
      case (a)
         32'h0000_0000: image = {32'h0000_0000, {4{32'h0000_0101}},
            32'h0000_0100, 32'h0000_0100, 32'h0000_0101};
         32'h0000_0020: image = {32'h0000_0000, {3{32'h0000_0100}},
            32'h3000_0100, 32'h2000_0100, {2{32'h0000_0100}}};
         default: image = {8{32'h0000_0000}};
      endcase
   endfunction
   // data flips every cycle when not valid, so stale words never match
   always @(posedge ref_clk) begin
      if (!rst_n) begin
         fetch_valid <= 1'b0;
         fetch_data <= {8{32'h0000_0000}};
         wait_ff <= 2'h0;
      end else if (fetch_req && !fetch_valid && wait_ff == lat) begin
         fetch_valid <= 1'b1;
         fetch_data <= image(fetch_addr);
         wait_ff <= 2'h0;
      end else begin
         fetch_valid <= 1'b0;
         fetch_data <= ~fetch_data;
         wait_ff <= (fetch_req && !fetch_valid) ? wait_ff + 2'h1 : 2'h0;
      end
   end
endmodule // prog_mem_model

// ===== vliw_packet_dispatch_tb_top.sv
// self-checking bench for the packet dispatcher
`timescale 1ns/1ps
`include "vliw_dispatch_defs.svh"
module vliw_packet_dispatch_tb_top;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [1:0] lat = 2'h0;
   logic fetch_req_ff, fetch_valid, cross_err_ff;
   logic [31:0] fetch_addr_ff;
   logic [255:0] fetch_data, issue_data_ff;
   logic [7:0] issue_mask_ff, issue_exec_ff;
   logic [7:0][4:0] rd_reg = '0;
   logic [7:0][4:0] result_reg = '0;
   logic [7:0][31:0] rd_data_ff;
   logic [7:0][31:0] result_data = '0;
   logic [7:0] result_we = 8'h00;
   logic [1:0][4:0] agu_base_reg = '0;
   logic [1:0][4:0] agu_blk_log2 = '0;
   logic [1:0][14:0] agu_offset = '0;
   logic [1:0] agu_long = 2'h0;
   logic [1:0] agu_circ = 2'h0;
   logic [1:0][1:0] agu_size = '0;
   logic [1:0][31:0] agu_addr_ff;
   logic [1:0][3:0] agu_be_ff;
   int bad_count = 0;
   int checked = 0;

   always #10 ref_clk = ~ref_clk;

   vliw_packet_dispatch uut (.ref_clk(ref_clk), .rst_n(rst_n),
      .fetch_req_ff(fetch_req_ff), .fetch_addr_ff(fetch_addr_ff),
      .fetch_valid(fetch_valid), .fetch_data(fetch_data),
      .issue_mask_ff(issue_mask_ff), .issue_exec_ff(issue_exec_ff),
      .issue_data_ff(issue_data_ff), .rd_reg(rd_reg),
      .rd_data_ff(rd_data_ff), .result_we(result_we),
      .result_reg(result_reg), .result_data(result_data),
      .cross_err_ff(cross_err_ff), .agu_base_reg(agu_base_reg),
      .agu_offset(agu_offset), .agu_long(agu_long),
      .agu_circ(agu_circ), .agu_blk_log2(agu_blk_log2),
      .agu_size(agu_size), .agu_addr_ff(agu_addr_ff),
      .agu_be_ff(agu_be_ff));
   prog_mem_model pmem (.ref_clk(ref_clk), .rst_n(rst_n),
      .fetch_req(fetch_req_ff), .fetch_addr(fetch_addr_ff),
      .fetch_valid(fetch_valid), .fetch_data(fetch_data), .lat(lat));

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic summarize();
      $display("compares %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
      input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   // a hung dispatcher ends the run instead of stalling it
   task automatic wait_issue();
      int n;
      n = 0;
      while (issue_mask_ff !== 8'h00 ? 1'b0 : n < 40) begin
         @(negedge ref_clk);
         n++;
      end
      if (n == 40) begin
         $display("wrong value issue_mask_ff expected nonzero seen 00");
         bad_count++;
         summarize();
      end
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // two packets, first chained 1,0,0,1,1,1,1,0 then all single slots
   task automatic test_dispatch(input logic [1:0] l);
      logic [7:0] em [11] = '{8'h03, 8'h04, 8'hf8, 8'h01, 8'h02, 8'h04,
         8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
      logic [7:0] ex [11] = '{8'h03, 8'h04, 8'h78, 8'h01, 8'h02, 8'h00,
         8'h08, 8'h10, 8'h20, 8'h40, 8'h00};
      @(posedge ref_clk);
      #1;
      rst_n = 1'b0;
      lat = l;
      repeat (12) @(posedge ref_clk);
      #1;
      rst_n = 1'b1;
      for (int i = 0; i < 11; i++) begin
         if (i == 0 || i == 3)
            wait_issue();
         check("issue_mask_ff", em[i], issue_mask_ff);
         check("issue_exec_ff", ex[i], issue_exec_ff);
         if (i == 0 || i == 2)
            check("fetch_req_ff", i == 2, fetch_req_ff);
         if (i == 2)
            check("fetch_addr_ff", 32'h20, fetch_addr_ff);
         if (i == 6)
            check("issue_data_ff", 32'h3000_0100,
               issue_data_ff[127:96]);
         if (i == 5 || i == 6)
            check("issue_exec_ff", ex[i], issue_exec_ff);
         if (i == 10)
            check("fetch_addr_ff", 32'h40, fetch_addr_ff);
         @(negedge ref_clk);
      end
      check("issue_mask_ff", 0, issue_mask_ff);
      $display("dispatch test done, wait states %0d", l);
   endtask
   // write both files, then read with two cross reads on side b
   task automatic test_regs();
      @(posedge ref_clk);
      #1;
      result_we = 8'h11;
      result_reg[0] = 5'h02;
      result_data[0] = 32'hdead_beef;
      result_reg[4] = 5'h11;
      result_data[4] = 32'h0000_1000;
      @(posedge ref_clk);
      #1;
      result_we = 8'h00;
      rd_reg = {5'h11, 5'h11, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02, 5'h02};
      @(posedge ref_clk);
      #1;
      rd_reg = '0;
      for (int u = 0; u < 4; u++)
         check("rd_data_ff", 32'hdead_beef, rd_data_ff[u]);
      check("rd_data_ff", 32'hdead_beef, rd_data_ff[4]);
      check("rd_data_ff", 32'h0, rd_data_ff[5]);
      check("cross_err_ff", 1, cross_err_ff);
      check("rd_data_ff", 32'h1000, rd_data_ff[7]);
      $display("register access test done");
   endtask
   // base taken from side b by both units, linear and circular
   task automatic test_agu();
      @(posedge ref_clk);
      #1;
      agu_base_reg = {5'h11, 5'h11};
      agu_offset = {15'h1234, 15'h0005};
      agu_long = 2'b10;
      agu_blk_log2 = {5'h00, 5'h04};
      agu_size = {`SIZE_WORD, `SIZE_HALF};
      @(posedge ref_clk);
      #1;
      agu_offset = {15'h7fe1, 15'h001f};
      agu_long = 2'b00;
      agu_circ = 2'b01;
      agu_size = {`SIZE_BYTE, `SIZE_BYTE};
      check("agu_addr_ff a", 32'h100a, agu_addr_ff[0]);
      check("agu_be_ff a", 4'hc, agu_be_ff[0]);
      check("agu_addr_ff b", 32'h58d0, agu_addr_ff[1]);
      check("agu_be_ff b", 4'hf, agu_be_ff[1]);
      @(posedge ref_clk);
      #1;
      check("agu_addr_ff a", 32'h100f, agu_addr_ff[0]);
      check("agu_be_ff a", 4'h8, agu_be_ff[0]);
      check("agu_addr_ff b", 32'h1001, agu_addr_ff[1]);
      check("agu_be_ff b", 4'h2, agu_be_ff[1]);
      $display("address unit test done");
   endtask

   // main sequence: prompt memory, slow memory, then data paths
   initial begin
      test_dispatch(2'h0);
      test_dispatch(2'h3);
      test_regs();
      test_agu();
      summarize();
   end
endmodule // vliw_packet_dispatch_tb_top
